/* File: hw/osw_cfg.svh */
// constants for the oscillator switch and reference clock output block
// assumes a 32-bit byte-addressed avalon-mm register port
`ifndef OSW_CFG_SVH
`define OSW_CFG_SVH

// ==========================================================
// register byte offsets
`define OSW_ADDR_W            4
`define OSW_OFS_OSC_CTRL      4'h0
`define OSW_OFS_REF_CTRL      4'h4
`define OSW_OFS_IRQ_STAT      4'h8
`define OSW_OFS_IRQ_MASK      4'hC

// ==========================================================
// oscillator control fields
`define OSW_GO_BIT            0
`define OSW_LOCK_BIT          5
`define OSW_NOSC_LSB          8
`define OSW_COSC_LSB          12
`define OSW_SRC_W             3
`define OSW_KEY_HI_1          8'h78
`define OSW_KEY_HI_2          8'h9A
`define OSW_KEY_LO_1          8'h46
`define OSW_KEY_LO_2          8'h57
`define OSW_COSC_RST          3'h0
`define OSW_NOSC_RST          3'h0

// ==========================================================
// reference control fields
`define OSW_REF_EN_BIT        15
`define OSW_REF_KEEP_BIT      13
`define OSW_REF_SEL_BIT       12
`define OSW_REF_DIV_LSB       8
`define OSW_REF_DIV_W         4
`define OSW_REF_CNT_W         16

// ==========================================================
// interrupt bits
`define OSW_EV_W              2
`define OSW_EV_DONE           0
`define OSW_EV_FAIL           1

// ==========================================================
// oscillator modes and timing
`define OSW_MODE_EC           2'h0
`define OSW_MODE_HS           2'h1
`define OSW_MODE_XT           2'h2
`define OSW_MODE_INT          2'h3
`define OSW_CLK_PERIOD_NS     50
`define OSW_SWITCH_TIMEOUT_NS 100000
`define OSW_TO_W              12

`endif

/* File: hw/osw_pkg.sv */
// types for the oscillator switch and reference clock output block
// assumes osw_cfg.svh is included before this package is compiled
`include "osw_cfg.svh"

package osw_pkg;

  // ==========================================================
  // state encodings
  typedef enum logic [1:0] {UL_IDLE, UL_FIRST, UL_OPEN} osw_unlock_t;
  typedef enum logic {SW_IDLE, SW_WAIT} osw_sw_t;

  // ==========================================================
  // whole block state
  typedef struct packed {
    logic [1:0]                   rdy_sync;
    logic [1:0]                   lock_sync;
    logic [2:0]                   prim_sync;
    osw_unlock_t                  hi_st;
    osw_unlock_t                  lo_st;
    logic [`OSW_SRC_W-1:0]        nosc;
    logic [`OSW_SRC_W-1:0]        cosc;
    logic                         go;
    logic                         lock;
    osw_sw_t                      sw_st;
    logic [`OSW_TO_W-1:0]         to_cnt;
    logic                         ref_en;
    logic                         ref_keep;
    logic                         ref_sel;
    logic [`OSW_REF_DIV_W-1:0]    ref_div;
    logic [`OSW_REF_CNT_W-1:0]    ref_cnt;
    logic                         ref_out;
    logic                         ref_oe_n;
    logic                         prim_en;
    logic                         half_rate_clock_pin;
    logic [`OSW_EV_W-1:0]         ev;
    logic [`OSW_EV_W-1:0]         mask;
    logic                         irq;
    logic                         wait_req;
    logic [31:0]                  rdata;
  } osw_state_t;

endpackage

/* File: hw/osw_top.sv */
// oscillator switch control and reference clock output, one clock domain
// assumes an avalon-mm master on clock_i and async oscillator status pins
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "osw_cfg.svh"

module osw_top (
  // clock and reset
  input  wire logic                    clock_i,
  input  wire logic                    srst_i,
  // avalon-mm slave
  input  wire logic [`OSW_ADDR_W-1:0]  address_i,
  input  wire logic                    read_i,
  input  wire logic                    write_i,
  input  wire logic [3:0]              byteenable_i,
  input  wire logic [31:0]             writedata_i,
  output logic      [31:0]             readdata_o,
  output logic                         waitrequest_o,
  // oscillator status pins and device state
  input  wire logic                    osc_ready_i,
  input  wire logic                    pll_lock_i,
  input  wire logic                    crystal_pin_one_i,
  input  wire logic [1:0]              osc_mode_i,
  input  wire logic                    sleep_i,
  // clock outputs
  output logic                         ref_output_pin_o,
  output logic                         ref_output_pin_oe_n_o,
  output logic                         half_rate_clock_pin_o,
  output logic                         primary_osc_enable_o,
  output logic [`OSW_SRC_W-1:0]        active_source_o,
  // interrupt
  output logic                         irq_o
);

  // ==========================================================
  // timing
  localparam int unsigned TO_CYC =
    `OSW_SWITCH_TIMEOUT_NS / `OSW_CLK_PERIOD_NS;
  localparam logic [`OSW_TO_W-1:0] TO_LAST = `OSW_TO_W'(TO_CYC - 1);

  osw_pkg::osw_state_t s_r;
  osw_pkg::osw_state_t s_nxt;

  // ==========================================================
  // bus decode
  logic                         req;
  logic                         wr_acc;
  logic                         rd_cap;
  logic                         hb_wr;
  logic                         lb_wr;
  logic [7:0]                   hb;
  logic [7:0]                   lb;
  logic                         primary_mode;
  logic                         run;
  logic                         src_evt;
  logic [`OSW_REF_CNT_W-1:0]    lim;
  logic [`OSW_EV_W-1:0]         ev_set;
  logic                         start;

  assign req    = read_i | write_i;
  // write lands on the edge where waitrequest is seen low
  assign wr_acc = write_i & ~s_r.wait_req;
  // read data and read-clear happen one edge earlier, so data stands
  assign rd_cap = read_i & s_r.wait_req;
  assign hb_wr  = wr_acc & (address_i == `OSW_OFS_OSC_CTRL)
                  & byteenable_i[1];
  assign lb_wr  = wr_acc & (address_i == `OSW_OFS_OSC_CTRL)
                  & byteenable_i[0];
  assign hb     = writedata_i[15:8];
  assign lb     = writedata_i[7:0];

  assign primary_mode = (osc_mode_i == `OSW_MODE_EC)
                      | (osc_mode_i == `OSW_MODE_HS)
                      | (osc_mode_i == `OSW_MODE_XT);
  // sleep keeps the output only from a running primary oscillator
  assign run = s_r.ref_en & (~sleep_i
             | (s_r.ref_keep & s_r.ref_sel & primary_mode));
  // system clock source ticks every cycle; primary on each pin edge
  assign src_evt = s_r.ref_sel ? (s_r.prim_sync[2] ^ s_r.prim_sync[1])
                               : 1'b1;
  assign lim = (`OSW_REF_CNT_W'(1) << s_r.ref_div)
             - `OSW_REF_CNT_W'(1);
  assign start = lb_wr & (s_r.lo_st == osw_pkg::UL_OPEN)
               & lb[`OSW_GO_BIT] & (s_r.sw_st == osw_pkg::SW_IDLE);

  // ==========================================================
  // next state
  always_comb begin
    s_nxt  = s_r;
    ev_set = '0;

    // pins pass two flops before anything looks at them
    s_nxt.rdy_sync  = {s_r.rdy_sync[0], osc_ready_i};
    s_nxt.lock_sync = {s_r.lock_sync[0], pll_lock_i};
    s_nxt.prim_sync = {s_r.prim_sync[1:0], crystal_pin_one_i};

    // high byte unlock; any accepted write moves the tracker
    if (wr_acc) begin
      case (s_r.hi_st)
        osw_pkg::UL_IDLE: begin
          s_nxt.hi_st = (hb_wr && hb == `OSW_KEY_HI_1) ?
                        osw_pkg::UL_FIRST : osw_pkg::UL_IDLE;
        end
        osw_pkg::UL_FIRST: begin
          s_nxt.hi_st = (hb_wr && hb == `OSW_KEY_HI_2) ?
                        osw_pkg::UL_OPEN : osw_pkg::UL_IDLE;
        end
        osw_pkg::UL_OPEN: begin
          if (hb_wr) begin
            s_nxt.nosc = writedata_i[`OSW_NOSC_LSB +: `OSW_SRC_W];
          end
          s_nxt.hi_st = osw_pkg::UL_IDLE;
        end
        default: begin
          s_nxt.hi_st = osw_pkg::UL_IDLE;
        end
      endcase

      // low byte unlock
      case (s_r.lo_st)
        osw_pkg::UL_IDLE: begin
          s_nxt.lo_st = (lb_wr && lb == `OSW_KEY_LO_1) ?
                        osw_pkg::UL_FIRST : osw_pkg::UL_IDLE;
        end
        osw_pkg::UL_FIRST: begin
          s_nxt.lo_st = (lb_wr && lb == `OSW_KEY_LO_2) ?
                        osw_pkg::UL_OPEN : osw_pkg::UL_IDLE;
        end
        osw_pkg::UL_OPEN: begin
          s_nxt.lo_st = osw_pkg::UL_IDLE;
        end
        default: begin
          s_nxt.lo_st = osw_pkg::UL_IDLE;
        end
      endcase

      if (address_i == `OSW_OFS_REF_CTRL && byteenable_i[1]) begin
        s_nxt.ref_en   = writedata_i[`OSW_REF_EN_BIT];
        s_nxt.ref_keep = writedata_i[`OSW_REF_KEEP_BIT];
        s_nxt.ref_sel  = writedata_i[`OSW_REF_SEL_BIT];
        s_nxt.ref_div  = writedata_i[`OSW_REF_DIV_LSB +: `OSW_REF_DIV_W];
      end
      if (address_i == `OSW_OFS_IRQ_MASK && byteenable_i[0]) begin
        s_nxt.mask = writedata_i[`OSW_EV_W-1:0];
      end
    end

    // clock switch; a failed attempt leaves go set until a later attempt succeeds
    s_nxt.lock = s_r.lock_sync[1];
    case (s_r.sw_st)
      osw_pkg::SW_IDLE: begin
        s_nxt.to_cnt = '0;
        if (start) begin
          s_nxt.go    = 1'b1;
          s_nxt.sw_st = osw_pkg::SW_WAIT;
        end
      end
      osw_pkg::SW_WAIT: begin
        s_nxt.to_cnt = s_r.to_cnt + `OSW_TO_W'(1);
        if (s_r.rdy_sync[1]) begin
          s_nxt.cosc  = s_r.nosc;
          s_nxt.go    = 1'b0;
          s_nxt.sw_st = osw_pkg::SW_IDLE;
          ev_set[`OSW_EV_DONE] = 1'b1;
        end else if (s_r.to_cnt == TO_LAST) begin
          s_nxt.sw_st = osw_pkg::SW_IDLE;
          ev_set[`OSW_EV_FAIL] = 1'b1;
        end
      end
      default: begin
        s_nxt.sw_st = osw_pkg::SW_IDLE;
      end
    endcase

    // reference divider
    if (!run) begin
      s_nxt.ref_cnt = '0;
      s_nxt.ref_out = 1'b0;
    end else if (src_evt) begin
      if (s_r.ref_cnt >= lim) begin
        s_nxt.ref_cnt = '0;
        s_nxt.ref_out = ~s_r.ref_out;
      end else begin
        s_nxt.ref_cnt = s_r.ref_cnt + `OSW_REF_CNT_W'(1);
      end
    end
    s_nxt.ref_oe_n = ~run;
    s_nxt.prim_en  = ~(sleep_i & ~s_r.ref_sel);
    // crystal modes use the second pin, so no half-rate clock there
    if (osc_mode_i == `OSW_MODE_EC || osc_mode_i == `OSW_MODE_INT) begin
      s_nxt.half_rate_clock_pin = ~s_r.half_rate_clock_pin;
    end else begin
      s_nxt.half_rate_clock_pin = 1'b0;
    end

    // bus answer: one wait cycle, then one cycle with waitrequest low
    s_nxt.wait_req = ~(req & s_r.wait_req);
    if (rd_cap) begin
      case (address_i)
        `OSW_OFS_OSC_CTRL: begin
          s_nxt.rdata = '0;
          s_nxt.rdata[`OSW_COSC_LSB +: `OSW_SRC_W] = s_r.cosc;
          s_nxt.rdata[`OSW_NOSC_LSB +: `OSW_SRC_W] = s_r.nosc;
          s_nxt.rdata[`OSW_LOCK_BIT] = s_r.lock;
          s_nxt.rdata[`OSW_GO_BIT]   = s_r.go;
        end
        `OSW_OFS_REF_CTRL: begin
          s_nxt.rdata = '0;
          s_nxt.rdata[`OSW_REF_EN_BIT]   = s_r.ref_en;
          s_nxt.rdata[`OSW_REF_KEEP_BIT] = s_r.ref_keep;
          s_nxt.rdata[`OSW_REF_SEL_BIT]  = s_r.ref_sel;
          s_nxt.rdata[`OSW_REF_DIV_LSB +: `OSW_REF_DIV_W] = s_r.ref_div;
        end
        `OSW_OFS_IRQ_STAT: begin
          s_nxt.rdata = {{(32-`OSW_EV_W){1'b0}}, s_r.ev};
        end
        `OSW_OFS_IRQ_MASK: begin
          s_nxt.rdata = {{(32-`OSW_EV_W){1'b0}}, s_r.mask};
        end
        default: begin
          s_nxt.rdata = '0;
        end
      endcase
    end

    // read clears status, a new event in the same cycle survives
    if (rd_cap && address_i == `OSW_OFS_IRQ_STAT) begin
      s_nxt.ev = ev_set;
    end else begin
      s_nxt.ev = s_r.ev | ev_set;
    end
    s_nxt.irq = |(s_nxt.ev & s_nxt.mask);
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      s_r          <= '0;
      s_r.wait_req <= 1'b1;
      s_r.ref_oe_n <= 1'b1;
      s_r.prim_en  <= 1'b1;
      s_r.cosc     <= `OSW_COSC_RST;
      s_r.nosc     <= `OSW_NOSC_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign readdata_o            = s_r.rdata;
  assign waitrequest_o         = s_r.wait_req;
  assign ref_output_pin_o      = s_r.ref_out;
  assign ref_output_pin_oe_n_o = s_r.ref_oe_n;
  assign half_rate_clock_pin_o = s_r.half_rate_clock_pin;
  assign primary_osc_enable_o  = s_r.prim_en;
  assign active_source_o       = s_r.cosc;
  assign irq_o                 = s_r.irq;

  // ==========================================================
  // checks
  property p_nosc_guard;
    @(posedge clock_i) disable iff (srst_i)
    (s_nxt.nosc != s_r.nosc) |-> (s_r.hi_st == osw_pkg::UL_OPEN) && hb_wr;
  endproperty
  a_nosc_guard: assert property (p_nosc_guard)
    else $error("new source changed without high unlock");

  property p_nosc_load;
    @(posedge clock_i) disable iff (srst_i)
    (s_r.hi_st == osw_pkg::UL_OPEN && hb_wr) |=>
      s_r.nosc == $past(writedata_i[`OSW_NOSC_LSB +: `OSW_SRC_W]);
  endproperty
  a_nosc_load: assert property (p_nosc_load)
    else $error("new source not loaded after unlock");

  property p_go_guard;
    @(posedge clock_i) disable iff (srst_i)
    $rose(s_r.go) |-> $past(s_r.lo_st == osw_pkg::UL_OPEN && lb_wr);
  endproperty
  a_go_guard: assert property (p_go_guard)
    else $error("go set without low unlock");

  property p_start;
    @(posedge clock_i) disable iff (srst_i)
    start |=> s_r.go && s_r.sw_st == osw_pkg::SW_WAIT;
  endproperty
  a_start: assert property (p_start)
    else $error("switch did not start");

  property p_done;
    @(posedge clock_i) disable iff (srst_i)
    (s_r.sw_st == osw_pkg::SW_WAIT && s_r.rdy_sync[1]) |=>
      !s_r.go && s_r.cosc == $past(s_r.nosc) && s_r.ev[`OSW_EV_DONE];
  endproperty
  a_done: assert property (p_done)
    else $error("successful switch did not clear go");

  property p_fail;
    @(posedge clock_i) disable iff (srst_i)
    (s_r.sw_st == osw_pkg::SW_WAIT && !s_r.rdy_sync[1]
      && s_r.to_cnt == TO_LAST) |=> s_r.go && s_r.ev[`OSW_EV_FAIL];
  endproperty
  a_fail: assert property (p_fail)
    else $error("failed switch lost go or event");

  property p_cancel;
    @(posedge clock_i) disable iff (srst_i)
    (s_r.hi_st == osw_pkg::UL_FIRST && wr_acc
      && !(hb_wr && hb == `OSW_KEY_HI_2)) |=> s_r.hi_st == osw_pkg::UL_IDLE;
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("stray write did not cancel unlock");

  property p_pin_off;
    @(posedge clock_i) disable iff (srst_i)
    !s_r.ref_en |=> s_r.ref_oe_n && !s_r.ref_out;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("reference pin driven while disabled");

  property p_sleep;
    @(posedge clock_i) disable iff (srst_i)
    (sleep_i && !(s_r.ref_keep && s_r.ref_sel && primary_mode)) |=>
      s_r.ref_oe_n;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("reference ran in sleep without permission");

  property p_prim_off;
    @(posedge clock_i) disable iff (srst_i)
    (sleep_i && !s_r.ref_sel) |=> !primary_osc_enable_o;
  endproperty
  a_prim_off: assert property (p_prim_off)
    else $error("primary oscillator kept on in sleep");

  property p_div0;
    @(posedge clock_i) disable iff (srst_i)
    (run && !s_r.ref_sel && s_r.ref_div == '0)[*2] |=>
      s_r.ref_out != $past(s_r.ref_out);
  endproperty
  a_div0: assert property (p_div0)
    else $error("divider zero did not pass source");

  property p_half_rate_clock_pin;
    @(posedge clock_i) disable iff (srst_i)
    (osc_mode_i == `OSW_MODE_EC) |=> s_r.half_rate_clock_pin != $past(s_r.half_rate_clock_pin);
  endproperty
  a_half_rate_clock_pin: assert property (p_half_rate_clock_pin)
    else $error("half-rate clock did not toggle");

  c_switch_ok: cover property (@(posedge clock_i) disable iff (srst_i)
    s_r.sw_st == osw_pkg::SW_WAIT ##1 s_r.sw_st == osw_pkg::SW_IDLE
    && !s_r.go);
  c_switch_fail: cover property (@(posedge clock_i) disable iff (srst_i)
    $rose(s_r.ev[1]));
  c_ref_sleep: cover property (@(posedge clock_i) disable iff (srst_i)
    sleep_i && !s_r.ref_oe_n);

endmodule

/* File: verification/osw_ext_model.sv */
// far side: primary crystal, oscillator ready and a load on the ref pin
// assumes the bench arms the ready answer and reads the edge count
`timescale 1ns/1ns

module osw_ext_model (
  // control and observed pin
  input  wire logic        arm_i,
  input  wire logic        ref_wire_i,
  // oscillator side
  output logic             xtal_o,
  output logic             ready_o,
  output logic [15:0]      edges_o
);
  // ==========================================================
  // oscillator
  // free running, unrelated in phase to the system clock
  initial begin
    xtal_o = 1'b0;
    forever #170 xtal_o = ~xtal_o;
  end

  // start-up time before ready; never ready when not armed
  initial begin
    ready_o = 1'b0;
    forever begin
      @(posedge arm_i);
      #1230;
      ready_o = arm_i;
      if (arm_i)
        @(negedge arm_i);
      ready_o = 1'b0;
    end
  end

  // ==========================================================
  // clocked load
  initial begin
    edges_o = 16'h0000;
    forever @(posedge ref_wire_i) edges_o <= edges_o + 16'h0001;
  end
endmodule

/* File: verification/tb_osw_top.sv */
// self-checking bench for the oscillator switch and reference output
// assumes osw_top and osw_ext_model are compiled before this file
`timescale 1ns/1ns
`include "osw_cfg.svh"

module tb_osw_top;
  logic        clock_i, srst_i, read_i, write_i, waitrequest_o;
  logic        xtal, rdy, lock, sleep, arm, ref_pin, ref_oe_n;
  logic        ref_wire, half, prim_en, irq, prev, run;
  logic [3:0]  address_i, byteenable_i, v;
  logic [31:0] writedata_i, readdata_o, q;
  logic [1:0]  mode;
  logic [2:0]  src_a, nsrc;
  logic [15:0] edges, e0;
  logic [3:0]  cs [4];
  int          miscompares, check_count, cyc, seed, i, n;

  always #25 clock_i = ~clock_i;
  // load has a pull-down, so an undriven pin reads low
  assign ref_wire = ref_oe_n ? 1'b0 : ref_pin;

  osw_top u_dut (
    .clock_i(clock_i), .srst_i(srst_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .byteenable_i(byteenable_i),
    .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .osc_ready_i(rdy),
    .pll_lock_i(lock), .crystal_pin_one_i(xtal), .osc_mode_i(mode),
    .sleep_i(sleep), .ref_output_pin_o(ref_pin),
    .ref_output_pin_oe_n_o(ref_oe_n), .half_rate_clock_pin_o(half),
    .primary_osc_enable_o(prim_en), .active_source_o(src_a),
    .irq_o(irq));

  osw_ext_model u_ext (
    .arm_i(arm), .ref_wire_i(ref_wire), .xtal_o(xtal),
    .ready_o(rdy), .edges_o(edges));

  // ==========================================================
  // checking and closing
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic near(input int got, input int exp, input int tol);
    check(got >= exp - tol && got <= exp + tol, 1'b1);
  endtask

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  // ==========================================================
  // avalon-mm master
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [3:0] be, input logic [31:0] d);
    read_i       <= !w;
    write_i      <= w;
    address_i    <= a;
    byteenable_i <= be;
    writedata_i  <= d;
    do @(posedge clock_i); while (waitrequest_o !== 1'b0);
    q = readdata_o;
    read_i  <= 1'b0;
    write_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    bus(1'b1, a, be, d);
  endtask

  task automatic rd(input logic [3:0] a);
    bus(1'b0, a, 4'hF, 32'h0000_0000);
  endtask

  // ==========================================================
  // unlock sequences, written back to back or with one stray write between
  task automatic hi_open(input logic [2:0] s, input logic stray);
    wr(`OSW_OFS_OSC_CTRL, 4'b0010, 32'h0000_7800);
    if (stray)
      wr(`OSW_OFS_IRQ_MASK, 4'b0001, 32'h0000_0000);
    wr(`OSW_OFS_OSC_CTRL, 4'b0010, 32'h0000_9A00);
    wr(`OSW_OFS_OSC_CTRL, 4'b0010, {21'h0, s, 8'h00});
  endtask

  task automatic lo_go(input logic stray);
    wr(`OSW_OFS_OSC_CTRL, 4'b0001, 32'h0000_0046);
    if (stray)
      wr(`OSW_OFS_IRQ_MASK, 4'b0001, 32'h0000_0000);
    wr(`OSW_OFS_OSC_CTRL, 4'b0001, 32'h0000_0057);
    wr(`OSW_OFS_OSC_CTRL, 4'b0001, 32'h0000_0001);
  endtask

  // masked event stays quiet, unmasked raises irq, read clears it
  task automatic irq_seq(input logic [1:0] st);
    repeat (3) @(posedge clock_i);
    check(irq, 1'b0);
    wr(`OSW_OFS_IRQ_MASK, 4'b0001, {30'h0, st});
    repeat (3) @(posedge clock_i);
    check(irq, 1'b1);
    rd(`OSW_OFS_IRQ_STAT);
    check(q[1:0], st);
    repeat (3) @(posedge clock_i);
    check(irq, 1'b0);
    wr(`OSW_OFS_IRQ_MASK, 4'b0001, 32'h0000_0000);
  endtask

  // ==========================================================
  // reference output measurement
  function automatic int sys_edges(input int d, input int c);
    return c >> (d + 1);
  endfunction

  task automatic meas(input logic [31:0] cfg, input int c);
    wr(`OSW_OFS_REF_CTRL, 4'b0010, cfg);
    repeat (8) @(posedge clock_i);
    e0 = edges;
    repeat (c) @(posedge clock_i);
    n = int'(edges - e0);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    clock_i = 1'b0; srst_i = 1'b1; read_i = 1'b0; write_i = 1'b0;
    address_i = 4'h0; byteenable_i = 4'h0; writedata_i = 32'h0;
    lock = 1'b0; sleep = 1'b0; arm = 1'b0; mode = 2'h1; seed = 18;
    cs = '{4'b1101, 4'b0101, 4'b1111, 4'b1000};
    repeat (16) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    check({waitrequest_o, ref_oe_n, prim_en, ref_pin, irq}, 5'h1C);
    foreach (cs[k]) begin
      rd(4'(k * 4));
      check(q, 32'h0000_0000);
    end
    rd(4'h2); // unmapped
    check(q, 32'h0000_0000);

    q = $random(seed);
    nsrc = q[2:0] | 3'h1;
    hi_open(nsrc, 1'b1);
    lo_go(1'b1);
    rd(`OSW_OFS_OSC_CTRL);
    check(q[10:8], 3'h0);
    check(q[0], 1'b0);
    hi_open(nsrc, 1'b0);
    rd(`OSW_OFS_OSC_CTRL);
    check(q[10:8], nsrc);
    arm <= 1'b1;
    lo_go(1'b0);
    rd(`OSW_OFS_OSC_CTRL);
    check(q[0], 1'b1);
    // poll while the new source settles
    for (i = 0; i < 200 && q[0] !== 1'b0; i++)
      rd(`OSW_OFS_OSC_CTRL);
    check(q[0], 1'b0);
    check(q[14:12], nsrc);
    check(src_a, nsrc);
    irq_seq(2'b01);
    arm <= 1'b0;

    q = $random(seed);
    lock <= q[4];
    hi_open(nsrc ^ 3'h6, 1'b0);
    lo_go(1'b0);
    repeat (2100) @(posedge clock_i);
    rd(`OSW_OFS_OSC_CTRL);
    check(q[0], 1'b1);
    check(q[5], lock);
    check(q[14:12], nsrc);
    irq_seq(2'b10);

    for (i = 0; i < 4; i++) begin
      mode <= 2'($random(seed));
      meas(32'h0000_8000 | (i << 8), 256);
      check(ref_oe_n, 1'b0);
      near(n, sys_edges(i, 256), 1);
    end
    meas(32'h0000_0300, 64);
    check({ref_oe_n, ref_pin}, 2'b10);
    check(n, 0);
    meas(32'h0000_9000, 680);
    near(n, 680 * 50 / 340, 2);

    for (i = 0; i < 4; i++) begin
      v = cs[i];
      mode  <= v[1:0];
      sleep <= 1'b1;
      meas({16'h0, 2'b10, v[3], v[2], 12'h000}, 200);
      run = v[3] & v[2] & (v[1:0] != 2'h3);
      check(ref_oe_n, !run);
      check(n > 10, run);
      check(prim_en, v[2]);
    end
    sleep <= 1'b0;

    for (i = 0; i < 4; i++) begin
      mode <= 2'(i);
      repeat (3) @(posedge clock_i);
      prev = half;
      n = 0;
      repeat (8) begin
        @(posedge clock_i);
        if (half !== prev)
          n++;
        prev = half;
      end
      check(n, (i == 0 || i == 3) ? 8 : 0);
    end
    give_verdict();
  end
endmodule
